// >>> common/fasr_pkg.sv
// Constants and types for the 48-bit floating add, subtract and divide datapath.
// Assumes a single synchronous clock domain shared with instruction control.
package fasr_pkg;

	// ==========================================================
	// Word layout
	localparam int          WORD_W       = 48;
	localparam int          HALF_W       = 24;
	localparam int          FRAC_W       = 36;
	localparam int          EXP_W        = 11;
	localparam int          SIGN_BIT     = 47;
	localparam int          EXP_MSB      = 46;
	localparam int          EXP_LSB      = 36;
	localparam int          FRAC_MSB     = 35;
	localparam int          ADDR_W       = 18;

	// ==========================================================
	// Exponent encoding
	localparam logic [10:0] EXP_BIAS_POS = 11'h400;
	localparam logic [10:0] EXP_BIAS_NEG = 11'h3ff;
	localparam logic [12:0] EXP_TRUE_MAX = 13'h3ff;

	// ==========================================================
	// Alignment, division and rounding counts
	localparam logic [6:0]  ALIGN_MAX    = 7'h3f;
	localparam logic [12:0] ALIGN_LIMIT  = 13'h024;
	localparam logic [5:0]  DIV_STEPS    = 6'h24;
	localparam int          E_ROUND_BIT  = 47;

	// ==========================================================
	// Fault flag positions
	localparam int          FLT_OVF      = 0;
	localparam int          FLT_UNF      = 1;
	localparam int          FLT_DIV      = 2;
	localparam logic [2:0]  FLT_RESET    = 3'h0;

	typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_DIV} fasr_op_type;

	typedef enum logic [3:0] {
		ST_IDLE, ST_IND, ST_FETCH_HI, ST_FETCH_LO, ST_CHECK,
		ST_ALIGN, ST_ARITH, ST_DIVIDE, ST_NORM, ST_PACK
	} fasr_state_type;

endpackage

// >>> core/fasr_core.sv
// Floating add, subtract and divide datapath with rounding, normalization and faults.
// Assumes instruction control holds the accumulator pair stable while busy is high
// and that storage answers each read request with a one-cycle acknowledge.
//
// Functional notes
// RQ1: Low 36 bits fraction, bit 47 sign.
// RQ2: Result fraction kept between half and one.
// RQ3: Eleven-bit exponent, biases octal 2000 and 1777.
// RQ4: Minus zero exponent biased as plus zero.
// RQ5: Biased words order like fixed point numbers.
// RQ6: Accumulator pair plus two storage words form operands.
// RQ7: Storage address supports indexing and indirection.
// RQ8: Alignment beyond 36 yields the larger operand.
// RQ9: Add shifts smaller-exponent fraction, max octal 77.
// RQ10: Subtract shifts accumulator or complemented storage fraction.
// RQ11: Round by one at lowest bit, before normalization.
// RQ12: Add/sub rounds when A23 and E47 differ.
// RQ13: A23 captured right after equalization finishes.
// RQ14: Divide rounds when residue ratio at least half.
// RQ15: Normalize by shifting, adjust exponent, residue untouched.
// RQ16: Faults: exponent overflow, underflow, bad divisor.
// RQ17: Sensing a fault flag clears it.
// RQ18: Program senses faults only after completion.
// RQ19: Each fault flag can request an interrupt.
// RQ20: Negative value is complement of whole word.
// RQ21: Result returns to accumulator pair, packed format.
`timescale 1ns/100ps

module fasr_core (
	input  wire logic                        mclk,
	input  wire logic                        reset,
	input  wire logic                        start,
	input  wire fasr_pkg::fasr_op_type       op,
	input  wire logic [fasr_pkg::HALF_W-1:0] acc_hi,
	input  wire logic [fasr_pkg::HALF_W-1:0] acc_lo,
	input  wire logic [fasr_pkg::ADDR_W-1:0] base_addr,
	input  wire logic [fasr_pkg::ADDR_W-1:0] index_val,
	input  wire logic                        index_en,
	input  wire logic                        indirect,
	input  wire logic                        mem_ack,
	input  wire logic [fasr_pkg::HALF_W-1:0] mem_data,
	input  wire logic                        fault_sense_op,
	input  wire logic [1:0]                  sense_sel,
	input  wire logic [2:0]                  irq_en,
	output logic                             mem_req,
	output logic [fasr_pkg::ADDR_W-1:0]      mem_addr,
	output logic [fasr_pkg::HALF_W-1:0]      result_hi,
	output logic [fasr_pkg::HALF_W-1:0]      result_lo,
	output logic [fasr_pkg::WORD_W-1:0]      ext_out,
	output logic                             result_we,
	output logic                             busy,
	output logic                             done,
	output logic                             sense_hit,
	output logic [2:0]                       fault_flags,
	output logic [2:0]                       irq_req
);
	import fasr_pkg::*;

	// ==========================================================
	// Helper functions
	function automatic logic signed [12:0] true_exp(input logic [10:0] biased);
		if (biased >= EXP_BIAS_POS) begin
			return $signed({2'b00, biased}) - $signed({2'b00, EXP_BIAS_POS}); // RQ4
		end
		return $signed({2'b00, biased}) - $signed({2'b00, EXP_BIAS_NEG}); // RQ3
	endfunction

	function automatic logic [10:0] bias_exp(input logic signed [12:0] t);
		logic [12:0] sum;
		sum = (t >= 0) ? 13'(t + $signed({2'b00, EXP_BIAS_POS}))
		               : 13'(t + $signed({2'b00, EXP_BIAS_NEG})); // RQ3 RQ4
		return sum[10:0];
	endfunction

	function automatic logic signed [37:0] signed_frac(input logic s, input logic [35:0] f);
		return s ? -$signed({2'b00, f}) : $signed({2'b00, f});
	endfunction

	function automatic logic [47:0] positive_word(input logic [47:0] w);
		return w[SIGN_BIT] ? ~w : w; // RQ20 RQ1
	endfunction

	// ==========================================================
	// State
	fasr_state_type      state_reg, state_next;
	fasr_op_type         op_reg, op_next;
	logic [ADDR_W-1:0]   addr_reg, addr_next;
	logic                mem_req_reg, mem_req_next;
	logic [HALF_W-1:0]   hi_reg, hi_next;
	logic                sa_reg, sa_next, sb_reg, sb_next;
	logic signed [12:0]  ea_reg, ea_next, eb_reg, eb_next;
	logic [35:0]         fa_reg, fa_next, fb_reg, fb_next;
	logic [47:0]         ext_reg, ext_next;
	logic [6:0]          cnt_reg, cnt_next;
	logic                sh_a_reg, sh_a_next;
	logic                a23_reg, a23_next;
	logic [36:0]         mag_reg, mag_next;
	logic                rsign_reg, rsign_next;
	logic signed [12:0]  exp_reg, exp_next;
	logic [37:0]         rem_reg, rem_next;
	logic [36:0]         dvs_reg, dvs_next;
	logic [5:0]          step_reg, step_next;
	logic [HALF_W-1:0]   res_hi_reg, res_hi_next, res_lo_reg, res_lo_next;
	logic [47:0]         ext_out_reg, ext_out_next;
	logic                we_reg, we_next, done_reg, done_next;
	logic                busy_reg, busy_next;
	logic                sense_hit_reg, sense_hit_next;
	logic [2:0]          fault_reg, fault_next, irq_reg, irq_next;

	// ==========================================================
	// Next-state computation
	always_comb begin
		logic [47:0]        mword;
		logic [47:0]        rword;
		logic signed [12:0] diff;
		logic signed [37:0] sum;
		logic signed [37:0] rnd;
		logic [37:0]        rem2;
		logic               qbit;
		logic               e47;
		logic               s_sh;
		logic [2:0]         flt_set;
		logic [2:0]         flt_clr;
		logic [47:0]        aword;
		mword = positive_word({hi_reg, mem_data});
		aword = positive_word({acc_hi, acc_lo});
		rword = '0;
		diff = ea_reg - eb_reg;
		sum = '0;
		rnd = '0;
		rem2 = {rem_reg[36:0], 1'b0};
		qbit = 1'b0;
		s_sh = sh_a_reg ? sa_reg : sb_reg;
		e47 = s_sh ? ~ext_reg[E_ROUND_BIT] : ext_reg[E_ROUND_BIT];
		flt_set = 3'h0;
		flt_clr = 3'h0;
		state_next = state_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		mem_req_next = mem_req_reg;
		hi_next = hi_reg;
		sa_next = sa_reg;
		sb_next = sb_reg;
		ea_next = ea_reg;
		eb_next = eb_reg;
		fa_next = fa_reg;
		fb_next = fb_reg;
		ext_next = ext_reg;
		cnt_next = cnt_reg;
		sh_a_next = sh_a_reg;
		a23_next = a23_reg;
		mag_next = mag_reg;
		rsign_next = rsign_reg;
		exp_next = exp_reg;
		rem_next = rem_reg;
		dvs_next = dvs_reg;
		step_next = step_reg;
		res_hi_next = res_hi_reg;
		res_lo_next = res_lo_reg;
		ext_out_next = ext_out_reg;
		we_next = 1'b0;
		done_next = 1'b0;
		sense_hit_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start) begin
					op_next = op;
					sa_next = acc_hi[HALF_W-1];
					hi_next = '0;
					addr_next = ADDR_W'(base_addr + (index_en ? index_val : '0)); // RQ7
					mem_req_next = 1'b1;
					ext_next = '0;
					cnt_next = '0;
					state_next = indirect ? ST_IND : ST_FETCH_HI; // RQ7
				end
			end
			ST_IND: begin
				if (mem_ack) begin
					addr_next = mem_data[ADDR_W-1:0]; // RQ7
					state_next = ST_FETCH_HI;
				end
			end
			ST_FETCH_HI: begin
				if (mem_ack) begin
					hi_next = mem_data;
					addr_next = ADDR_W'(addr_reg + 1'b1); // RQ6
					state_next = ST_FETCH_LO;
				end
			end
			ST_FETCH_LO: begin
				if (mem_ack) begin
					mem_req_next = 1'b0;
					sa_next = acc_hi[HALF_W-1];
					ea_next = true_exp(aword[EXP_MSB:EXP_LSB]); // RQ6
					fa_next = aword[FRAC_MSB:0]; // RQ1
					sb_next = hi_reg[HALF_W-1] ^ (op_reg == OP_SUB); // RQ10
					eb_next = true_exp(mword[EXP_MSB:EXP_LSB]);
					fb_next = mword[FRAC_MSB:0]; // RQ1
					state_next = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (op_reg == OP_DIV) begin
					rsign_next = sa_reg ^ sb_reg;
					a23_next = sa_reg ^ sb_reg;
					mag_next = '0;
					rem_next = {2'b00, fa_reg};
					step_next = '0;
					if (fb_reg == '0 || !fb_reg[FRAC_MSB]) begin
						flt_set[FLT_DIV] = 1'b1; // RQ16
						done_next = 1'b1;
						state_next = ST_IDLE;
					end else if (fa_reg >= fb_reg) begin
						dvs_next = {fb_reg, 1'b0};
						exp_next = 13'(ea_reg - eb_reg + 13'sd1);
						state_next = ST_DIVIDE;
					end else begin
						dvs_next = {1'b0, fb_reg};
						exp_next = 13'(ea_reg - eb_reg);
						state_next = ST_DIVIDE;
					end
				end else if (diff > $signed(ALIGN_LIMIT) || diff < -$signed(ALIGN_LIMIT)) begin
					rsign_next = (diff > 0) ? sa_reg : sb_reg; // RQ8
					exp_next = (diff > 0) ? ea_reg : eb_reg;
					mag_next = {1'b0, (diff > 0) ? fa_reg : fb_reg};
					state_next = ST_NORM;
				end else begin
					state_next = ST_ALIGN;
				end
			end
			ST_ALIGN: begin
				if (ea_reg == eb_reg || cnt_reg == ALIGN_MAX) begin
					a23_next = sa_reg; // RQ13
					state_next = ST_ARITH;
				end else if (ea_reg < eb_reg) begin
					ext_next = {fa_reg[0], ext_reg[47:1]}; // RQ9 RQ10
					fa_next = {1'b0, fa_reg[35:1]};
					ea_next = 13'(ea_reg + 13'sd1);
					sh_a_next = 1'b1;
					cnt_next = 7'(cnt_reg + 1'b1);
				end else begin
					ext_next = {fb_reg[0], ext_reg[47:1]}; // RQ9 RQ10
					fb_next = {1'b0, fb_reg[35:1]};
					eb_next = 13'(eb_reg + 13'sd1);
					sh_a_next = 1'b0;
					cnt_next = 7'(cnt_reg + 1'b1);
				end
			end
			ST_ARITH: begin
				if (cnt_reg != '0 && !a23_reg && e47) begin
					rnd = 38'sd1; // RQ12
				end else if (cnt_reg != '0 && a23_reg && !e47) begin
					rnd = -38'sd1; // RQ12
				end
				sum = signed_frac(sa_reg, fa_reg) + signed_frac(sb_reg, fb_reg) + rnd; // RQ11
				rsign_next = sum[37];
				mag_next = sum[37] ? 37'(-sum) : sum[36:0];
				exp_next = ea_reg;
				ext_out_next = ext_reg; // RQ6
				state_next = ST_NORM;
			end
			ST_DIVIDE: begin
				if (step_reg == DIV_STEPS) begin
					if ({rem_reg[36:0], 1'b0} >= {1'b0, dvs_reg}) begin
						mag_next = 37'(mag_reg + 1'b1); // RQ14 RQ11
					end
					ext_out_next = {10'h000, rem_reg}; // RQ6
					state_next = ST_NORM;
				end else begin
					qbit = rem2 >= {1'b0, dvs_reg};
					rem_next = qbit ? 38'(rem2 - {1'b0, dvs_reg}) : rem2;
					mag_next = {1'b0, mag_reg[34:0], qbit};
					step_next = 6'(step_reg + 1'b1);
				end
			end
			ST_NORM: begin
				if (mag_reg[36]) begin
					mag_next = {1'b0, mag_reg[36:1]}; // RQ15 RQ2
					exp_next = 13'(exp_reg + 13'sd1);
				end else if (mag_reg != '0 && !mag_reg[FRAC_MSB]) begin
					mag_next = {mag_reg[35:0], 1'b0}; // RQ15 RQ2
					exp_next = 13'(exp_reg - 13'sd1);
				end else begin
					state_next = ST_PACK;
				end
			end
			ST_PACK: begin
				rword = {1'b0, bias_exp(exp_reg), mag_reg[FRAC_MSB:0]}; // RQ5
				if (rsign_reg) begin
					rword = ~rword; // RQ20
				end
				if (mag_reg == '0) begin
					rword = '0;
				end
				if (mag_reg != '0 && exp_reg > $signed(EXP_TRUE_MAX)) begin
					flt_set[FLT_OVF] = 1'b1; // RQ16
				end else if (mag_reg != '0 && exp_reg < -$signed(EXP_TRUE_MAX)) begin
					flt_set[FLT_UNF] = 1'b1; // RQ16
				end else begin
					res_hi_next = rword[47:24]; // RQ21
					res_lo_next = rword[23:0];
					we_next = 1'b1;
				end
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (fault_sense_op && sense_sel != 2'h3) begin
			sense_hit_next = fault_reg[sense_sel]; // RQ17
			flt_clr[sense_sel] = 1'b1; // RQ17
		end
		busy_next = (state_next != ST_IDLE);
		fault_next = (fault_reg & ~flt_clr) | flt_set;
		irq_next = fault_next & irq_en; // RQ19
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_ADD;
			addr_reg <= '0;
			mem_req_reg <= 1'b0;
			hi_reg <= '0;
			sa_reg <= 1'b0;
			sb_reg <= 1'b0;
			ea_reg <= '0;
			eb_reg <= '0;
			fa_reg <= '0;
			fb_reg <= '0;
			ext_reg <= '0;
			cnt_reg <= '0;
			sh_a_reg <= 1'b0;
			a23_reg <= 1'b0;
			mag_reg <= '0;
			rsign_reg <= 1'b0;
			exp_reg <= '0;
			rem_reg <= '0;
			dvs_reg <= '0;
			step_reg <= '0;
			res_hi_reg <= '0;
			res_lo_reg <= '0;
			ext_out_reg <= '0;
			we_reg <= 1'b0;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
			sense_hit_reg <= 1'b0;
			fault_reg <= FLT_RESET;
			irq_reg <= FLT_RESET;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			mem_req_reg <= mem_req_next;
			hi_reg <= hi_next;
			sa_reg <= sa_next;
			sb_reg <= sb_next;
			ea_reg <= ea_next;
			eb_reg <= eb_next;
			fa_reg <= fa_next;
			fb_reg <= fb_next;
			ext_reg <= ext_next;
			cnt_reg <= cnt_next;
			sh_a_reg <= sh_a_next;
			a23_reg <= a23_next;
			mag_reg <= mag_next;
			rsign_reg <= rsign_next;
			exp_reg <= exp_next;
			rem_reg <= rem_next;
			dvs_reg <= dvs_next;
			step_reg <= step_next;
			res_hi_reg <= res_hi_next;
			res_lo_reg <= res_lo_next;
			ext_out_reg <= ext_out_next;
			we_reg <= we_next;
			done_reg <= done_next;
			busy_reg <= busy_next;
			sense_hit_reg <= sense_hit_next;
			fault_reg <= fault_next;
			irq_reg <= irq_next;
		end
	end

	// ==========================================================
	// Outputs
	assign mem_req     = mem_req_reg;
	assign mem_addr    = addr_reg;
	assign result_hi   = res_hi_reg;
	assign result_lo   = res_lo_reg;
	assign ext_out     = ext_out_reg;
	assign result_we   = we_reg;
	assign busy        = busy_reg;
	assign done        = done_reg;
	assign sense_hit   = sense_hit_reg;
	assign fault_flags = fault_reg;
	assign irq_req     = irq_reg;

endmodule

// >>> verification/fasr_asserts.sv
// Port checker for the floating add, subtract and divide core.
// Bound to fasr_core from tb_top; one clock, synchronous reset.
`timescale 1ns/100ps

module fasr_asserts (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic       start,
	input wire logic       fault_sense_op,
	input wire logic [1:0] sense_sel,
	input wire logic [2:0] irq_en,
	input wire logic       mem_req,
	input wire logic [23:0] result_hi,
	input wire logic [23:0] result_lo,
	input wire logic       result_we,
	input wire logic       busy,
	input wire logic       done,
	input wire logic       sense_hit,
	input wire logic [2:0] fault_flags,
	input wire logic [2:0] irq_req
);
	import fasr_pkg::*;
	// ====
	// Helpers
	wire logic [47:0] word;
	wire logic        sense_idle;
	assign word = {result_hi, result_lo};
	assign sense_idle = fault_sense_op && sense_sel != 2'h3 && !busy && !done;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// ====
	// Assertions
	a_req_busy: assert property (mem_req |-> busy)
		else $error("storage request outside an operation");
	a_we_done: assert property (result_we |-> done)
		else $error("result written without done");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_start_busy: assert property (start && !busy |=> busy)
		else $error("start not taken");
	a_op_bound: assert property (start && !busy |-> ##[1:300] done)
		else $error("operation never finished");
	a_norm_frac: assert property (result_we && word != '0 && word != '1
		|-> result_hi[11] != result_hi[23])
		else $error("result fraction not normalized");
	a_fault_no_we: assert property (|(fault_flags & ~$past(fault_flags)) |-> !result_we)
		else $error("result written on a fault");
	a_flag_sticky: assert property (!$past(reset) && |($past(fault_flags) & ~fault_flags)
		|-> $past(fault_sense_op))
		else $error("fault flag dropped without sense");
	a_sense_val: assert property (sense_idle |=> sense_hit == $past(fault_flags[sense_sel]))
		else $error("sense returned wrong flag");
	a_sense_clr: assert property (sense_idle |=> !fault_flags[$past(sense_sel)])
		else $error("sensed flag not cleared");
	a_irq_mask: assert property ($stable(irq_en) |-> irq_req == (fault_flags & irq_en))
		else $error("interrupt request not masked flag");
	c_result: cover property (result_we);
	c_fault: cover property (|fault_flags);
	c_sense: cover property (sense_hit);
endmodule

// >>> verification/fasr_mem_model.sv
// Storage model answering the core's read requests.
// Latency in cycles set by lat; released data bus toggles.
`timescale 1ns/100ps

module fasr_mem_model (
	input wire logic                        mclk,
	input wire logic                        reset,
	input wire logic                        mem_req,
	input wire logic [fasr_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [1:0]                  lat,
	output logic                            mem_ack,
	output logic [fasr_pkg::HALF_W-1:0]     mem_data
);
	import fasr_pkg::*;
	logic [HALF_W-1:0] words [0:63];
	logic [1:0]        wait_cnt;
	// ====
	// Read answer
	always_ff @(posedge mclk) begin
		if (reset) begin
			mem_ack <= 1'b0;
			mem_data <= 24'h0;
			wait_cnt <= 2'h0;
		end else if (mem_req && !mem_ack && wait_cnt == lat) begin
			mem_ack <= 1'b1;
			mem_data <= words[mem_addr[5:0]];
			wait_cnt <= 2'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
			if (mem_req && !mem_ack) begin
				wait_cnt <= wait_cnt + 2'h1;
			end
		end
	end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench: plays instruction control for the core.
// Storage model answers reads; checker bound below.
`timescale 1ns/100ps

module tb_top;
	import fasr_pkg::*;
	logic        mclk = 0, reset = 1, start = 0, index_en = 0, indirect = 0;
	logic        fault_sense_op = 0, result_we, busy, done, sense_hit, mem_req, mem_ack;
	fasr_op_type op = OP_ADD;
	logic [23:0] acc_hi = 0, acc_lo = 0, mem_data, result_hi, result_lo;
	logic [17:0] base_addr = 18'h10, index_val = 0, mem_addr;
	logic [1:0]  sense_sel = 0, lat = 0;
	logic [2:0]  irq_en = 0, fault_flags, irq_req;
	logic [47:0] ext_out;
	int          n_mismatch = 0, samples_checked = 0;
	localparam logic [47:0] HALF = 48'h400800000000;
	always #4 mclk = ~mclk;
	fasr_core dut (.mclk, .reset, .start, .op, .acc_hi, .acc_lo, .base_addr, .index_val,
		.index_en, .indirect, .mem_ack, .mem_data, .fault_sense_op, .sense_sel, .irq_en,
		.mem_req, .mem_addr, .result_hi, .result_lo, .ext_out, .result_we, .busy, .done,
		.sense_hit, .fault_flags, .irq_req);
	fasr_mem_model mem_i (.mclk, .reset, .mem_req, .mem_addr, .lat, .mem_ack, .mem_data);
	// ====
	// Shared tasks
	task automatic check(input logic [47:0] seen, input logic [47:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask
	task automatic summarize;
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic run_op(input fasr_op_type o, input logic [47:0] a, input logic [47:0] m);
		int n;
		n = 0;
		mem_i.words[16] = m[47:24];
		mem_i.words[17] = m[23:0];
		@(posedge mclk);
		op <= o;
		acc_hi <= a[47:24];
		acc_lo <= a[23:0];
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		#1;
		while (done !== 1'b1 && n < 400) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(done, 1'b1);
	endtask
	task automatic res(input logic [47:0] w);
		check(result_we, 1'b1);
		check({result_hi, result_lo}, w);
	endtask
	task automatic sense(input logic [1:0] sel, input logic hit);
		@(posedge mclk);
		fault_sense_op <= 1'b1;
		sense_sel <= sel;
		@(posedge mclk);
		fault_sense_op <= 1'b0;
		#1;
		check(sense_hit, hit);
		check(fault_flags[sel], 1'b0);
	endtask
	// ====
	// Scenarios
	task automatic t_add;
		#1;
		check(fault_flags, 3'h0);
		run_op(OP_ADD, HALF, HALF);
		res(48'h401800000000);
		run_op(OP_ADD, 48'hbff7ffffffff, 48'hbff7ffffffff);
		res(48'hbfe7ffffffff);
	endtask
	task automatic t_sub;
		lat <= 2'h2;
		run_op(OP_SUB, 48'h400c00000000, HALF);
		res(48'h3fe800000000);
		run_op(OP_SUB, 48'h401800000000, 48'h400c00000000);
		res(48'h3fe800000004);
		run_op(OP_SUB, HALF, HALF);
		res(48'h0);
		lat <= 2'h0;
	endtask
	task automatic t_align;
		run_op(OP_ADD, 48'h403800000000, HALF);
		res(48'h403900000000);
		run_op(OP_ADD, 48'h428800000000, HALF);
		res(48'h428800000000);
		run_op(OP_SUB, HALF, 48'h428800000000);
		res(48'hbd77ffffffff);
	endtask
	task automatic t_round;
		run_op(OP_ADD, 48'h401800000000, 48'h400800000001);
		res(48'h401c00000001);
		check(ext_out[47], 1'b1);
		run_op(OP_ADD, 48'hbfe7ffffffff, 48'hbff7fffffffe);
		res(48'hbfe3fffffffe);
	endtask
	task automatic t_div;
		mem_i.words[8] = 24'h000014;
		mem_i.words[20] = 24'h400c00;
		mem_i.words[21] = 24'h000000;
		@(posedge mclk);
		base_addr <= 18'h5;
		index_val <= 18'h3;
		index_en <= 1'b1;
		indirect <= 1'b1;
		run_op(OP_DIV, HALF, HALF);
		res(48'h400aaaaaaaab);
		@(posedge mclk);
		base_addr <= 18'h10;
		index_en <= 1'b0;
		indirect <= 1'b0;
		run_op(OP_DIV, HALF, HALF);
		res(48'h401800000000);
		run_op(OP_DIV, HALF, 48'h0);
		check(result_we, 1'b0);
		@(posedge mclk);
		#1;
		check(fault_flags[2], 1'b1);
		sense(2'h2, 1'b1);
		run_op(OP_DIV, HALF, 48'h400400000000);
		check(result_we, 1'b0);
		@(posedge mclk);
		#1;
		check(fault_flags[2], 1'b1);
		sense(2'h2, 1'b1);
	endtask
	task automatic t_exp_fault;
		@(posedge mclk);
		irq_en <= 3'h7;
		run_op(OP_ADD, 48'h7ff800000000, 48'h7ff800000000);
		check(result_we, 1'b0);
		@(posedge mclk);
		#1;
		check(fault_flags[0], 1'b1);
		check(irq_req[0], 1'b1);
		sense(2'h0, 1'b1);
		check(irq_req[0], 1'b0);
		@(posedge mclk);
		irq_en <= 3'h0;
		run_op(OP_SUB, 48'h000c00000000, HALF & 48'h000fffffffff);
		@(posedge mclk);
		#1;
		check(fault_flags[1], 1'b1);
		check(irq_req[1], 1'b0);
		sense(2'h1, 1'b1);
		sense(2'h1, 1'b0);
	endtask
	// ====
	// Main sequence and watchdog
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_add();
		t_sub();
		t_align();
		t_round();
		t_div();
		t_exp_fault();
		summarize();
	end
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
endmodule

bind fasr_core fasr_asserts chk (.mclk, .reset, .start, .fault_sense_op, .sense_sel,
	.irq_en, .mem_req, .result_hi, .result_lo, .result_we, .busy, .done, .sense_hit,
	.fault_flags, .irq_req);
